// [verilog/fpg_port.sv]
// Design decision made here: the Wishbone slave port.
`timescale 1ns/1ps
`include "fpg_params.svh"
// Index i of pin vectors is fan pin i+1 (pin1 = index 0)
module fpg_port (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [31:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic wb_stb_i,
    input wire logic wb_cyc_i,
    output logic wb_ack_o,
    input wire fpg_pkg::fpg_pins_t fan_drive,
    input wire fpg_pkg::fpg_pins_t min_duty_lsb,
    input wire fpg_pkg::fpg_pins_t pin_in,
    output fpg_pkg::fpg_pins_t pin_out,
    output fpg_pkg::fpg_pins_t pin_oe
);
    import fpg_pkg::*;

    fpg_byte_t enable_reg;
    fpg_byte_t config_reg;
    fpg_pins_t level_out_reg;
    fpg_pins_t pin_sync;
    fpg_pins_t io_sel;
    fpg_pins_t dir;
    fpg_pins_t pol;
    fpg_pins_t in_asserted;
    fpg_pins_t status_view;
    fpg_pins_t pin_out_next;
    fpg_pins_t pin_oe_next;
    fpg_pins_t level_out_next;
    fpg_byte_t status_byte;
    logic [31:0] rd_next;

    // Byte address equals printed offset, so word-aligned decode is not used
    function automatic logic hit(input logic [31:0] adr, input logic [7:0] off);
        hit = (adr == {24'h000000, off});
    endfunction : hit

    wire access = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wire wr_lane = access && wb_we_i && wb_sel_i[0];
    wire wr_enable = wr_lane && hit(wb_adr_i, `FPG_ADDR_ENABLE);
    wire wr_config = wr_lane && hit(wb_adr_i, `FPG_ADDR_CONFIG);
    wire wr_status = wr_lane && hit(wb_adr_i, `FPG_ADDR_STATUS);
    wire rd_enable = access && !wb_we_i && hit(wb_adr_i, `FPG_ADDR_ENABLE);
    wire rd_status = access && !wb_we_i && hit(wb_adr_i, `FPG_ADDR_STATUS);

    fpg_sync #(.WIDTH(4)) u_sync (
        .clk(clk),
        .sys_rst(sys_rst),
        .async_in(pin_in),
        .sync_out(pin_sync)
    );

    genvar i;
    generate
        for (i = 0; i < 4; i++) begin : g_pin
            assign io_sel[i] = enable_reg[`FPG_SEL_MSB-i];
            assign dir[i] = config_reg[`FPG_DIR_MSB-2*i];
            assign pol[i] = config_reg[`FPG_POL_MSB-2*i];
            assign in_asserted[i] = pol[i] ? pin_sync[i] : !pin_sync[i];
            // Duty LSB or software status bit asserts the output (OR of both sources)
            assign pin_out_next[i] = !io_sel[i] ? fan_drive[i] :
                ((min_duty_lsb[i] | level_out_reg[i]) ? pol[i] : !pol[i]);
            assign pin_oe_next[i] = !io_sel[i] || dir[i];
            assign status_view[i] = !io_sel[i] ? 1'b0 :
                (dir[i] ? level_out_reg[i] : in_asserted[i]);
            assign level_out_next[i] = (wr_status && io_sel[i] && dir[i]) ?
                wb_dat_i[`FPG_STATUS_LSB+i] : level_out_reg[i];
        end
    endgenerate

    assign status_byte = {status_view, 4'h0};
    assign rd_next = hit(wb_adr_i, `FPG_ADDR_ENABLE) ? {24'h000000, enable_reg} :
                     hit(wb_adr_i, `FPG_ADDR_CONFIG) ? {24'h000000, config_reg} :
                     hit(wb_adr_i, `FPG_ADDR_STATUS) ? {24'h000000, status_byte} :
                     32'h00000000;

    // Register bank: a write lands at the taking edge, the same edge that raises ack
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            enable_reg <= `FPG_RESET_VALUE;
        end else if (wr_enable) begin
            // Reserved enable bits are kept zero whatever software writes
            enable_reg <= wb_dat_i[7:0] & `FPG_ENABLE_USED_MASK;
        end
    end

    // Select bits map in reverse order: bit 3 is pin 1, bit 0 is pin 4
    chk_pin1_map: assert property (@(posedge clk) disable iff (sys_rst)
        wr_enable |=> io_sel[0] == $past(wb_dat_i[3]))
        else $error("pin1 select mismatch");
    chk_pin2_map: assert property (@(posedge clk) disable iff (sys_rst)
        wr_enable |=> io_sel[1] == $past(wb_dat_i[2]))
        else $error("pin2 select mismatch");
    chk_pin3_map: assert property (@(posedge clk) disable iff (sys_rst)
        wr_enable |=> io_sel[2] == $past(wb_dat_i[1]))
        else $error("pin3 select mismatch");
    chk_pin4_map: assert property (@(posedge clk) disable iff (sys_rst)
        wr_enable |=> io_sel[3] == $past(wb_dat_i[0]))
        else $error("pin4 select mismatch");
    chk_enable_rsvd: assert property (@(posedge clk) disable iff (sys_rst)
        wb_ack_o && $past(rd_enable) |-> wb_dat_o[7:4] == 4'h0)
        else $error("reserved enable bits set");

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            config_reg <= `FPG_RESET_VALUE;
        end else if (wr_config) begin
            config_reg <= wb_dat_i[7:0];
        end
    end

    chk_config_write: assert property (@(posedge clk) disable iff (sys_rst)
        wr_config |=> config_reg == $past(wb_dat_i[7:0]))
        else $error("config write lost");

    // Software level of an output pin; kept while the pin is input or fan drive
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            level_out_reg <= `FPG_PINS_RESET;
        end else begin
            level_out_reg <= level_out_next;
        end
    end

    chk_level_write: assert property (@(posedge clk) disable iff (sys_rst)
        wr_status && io_sel[0] && dir[0] |=> level_out_reg[0] == $past(wb_dat_i[4]))
        else $error("output level not written");
    chk_level_hold: assert property (@(posedge clk) disable iff (sys_rst)
        !(io_sel[2] && dir[2]) |=> $stable(level_out_reg[2]))
        else $error("input level written");

    // The !ack term in access keeps each ack one cycle wide; a master holding stb gets ack every other cycle
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end else begin
            wb_ack_o <= access;
            wb_dat_o <= (access && !wb_we_i) ? rd_next : 32'h00000000;
        end
    end

    // Read data in the ack cycle was built from the values seen at the taking edge
    chk_input_status: assert property (@(posedge clk) disable iff (sys_rst)
        wb_ack_o && $past(rd_status) && $past(io_sel[0]) && !$past(dir[0])
        |-> wb_dat_o[4] == ($past(pol[0]) == $past(pin_sync[0])))
        else $error("input status mismatch");
    chk_status_pin3: assert property (@(posedge clk) disable iff (sys_rst)
        wb_ack_o && $past(rd_status) && $past(io_sel[2]) && !$past(dir[2])
        |-> wb_dat_o[6] == ($past(pol[2]) == $past(pin_sync[2])))
        else $error("pin3 input status mismatch");
    chk_status_pin4: assert property (@(posedge clk) disable iff (sys_rst)
        wb_ack_o && $past(rd_status) && $past(io_sel[3]) && !$past(dir[3])
        |-> wb_dat_o[7] == ($past(pol[3]) == $past(pin_sync[3])))
        else $error("pin4 status bit misplaced");
    chk_status_pin1: assert property (@(posedge clk) disable iff (sys_rst)
        wb_ack_o && $past(rd_status) && $past(io_sel[0]) && $past(dir[0])
        |-> wb_dat_o[4] == $past(level_out_reg[0]))
        else $error("output status mismatch");
    chk_unsel_status: assert property (@(posedge clk) disable iff (sys_rst)
        wb_ack_o && $past(rd_status) && !$past(io_sel[1]) |-> !wb_dat_o[5])
        else $error("status set on fan pin");

    // Pins stay driven through reset so a fan input never floats
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            pin_out <= `FPG_PINS_RESET;
            pin_oe <= `FPG_OE_RESET;
        end else begin
            pin_out <= pin_out_next;
            pin_oe <= pin_oe_next;
        end
    end

    chk_fan_pass: assert property (@(posedge clk) disable iff (sys_rst)
        !io_sel[2] && $stable(io_sel[2]) |=> pin_out[2] == $past(fan_drive[2]) && pin_oe[2])
        else $error("fan waveform not passed");
    chk_fan_pin4: assert property (@(posedge clk) disable iff (sys_rst)
        !io_sel[3] |=> pin_out[3] == $past(fan_drive[3]))
        else $error("pin4 fan waveform not passed");
    chk_fan_oe: assert property (@(posedge clk) disable iff (sys_rst)
        !io_sel[0] |=> pin_oe[0])
        else $error("fan pin released");
    chk_out_level: assert property (@(posedge clk) disable iff (sys_rst)
        io_sel[0] && dir[0] && level_out_reg[0] |=> pin_oe[0] && pin_out[0] == $past(pol[0]))
        else $error("output not asserted");
    chk_duty_pin1: assert property (@(posedge clk) disable iff (sys_rst)
        io_sel[0] && dir[0] && min_duty_lsb[0] |=> pin_out[0] == $past(pol[0]))
        else $error("pin1 duty lsb not driven");
    chk_duty_drive: assert property (@(posedge clk) disable iff (sys_rst)
        io_sel[1] && dir[1] && min_duty_lsb[1] |=> pin_out[1] == $past(pol[1]))
        else $error("duty lsb not driven");
    chk_pol_low: assert property (@(posedge clk) disable iff (sys_rst)
        io_sel[1] && dir[1] && !min_duty_lsb[1] && !level_out_reg[1]
        |=> pin_out[1] == !$past(pol[1]))
        else $error("idle output level wrong");
    chk_input_hiz: assert property (@(posedge clk) disable iff (sys_rst)
        io_sel[0] && !dir[0] |=> !pin_oe[0])
        else $error("input pin driven");
    chk_dir_pin3: assert property (@(posedge clk) disable iff (sys_rst)
        io_sel[2] && !dir[2] |=> !pin_oe[2])
        else $error("pin3 input driven");
    chk_output_drive: assert property (@(posedge clk) disable iff (sys_rst)
        io_sel[1] && dir[1] |=> pin_oe[1])
        else $error("output pin released");
endmodule : fpg_port

// [verilog/fpg_params.svh]
// Operation
// - Enable bit set turns that fan pin into GPIO; bit3 pin1 ... bit0 pin4.
// - Config bits 7,5,3,1 set direction of I/O 1..4; one means output.
// - Config bits 6,4,2,0 set polarity of I/O 1..4; one means active high.
// - Output value comes from LSB of that fan's minimum duty register.
// - Input status bit is read-only, set while pin sits at asserted level.
// - Output status bit is writable; setting it asserts the pin per polarity.
// - Status bits 7..4 show I/O 4..1, only while that pin is GPIO.
// - Enable, config and status registers are zero after reset.
`ifndef FPG_PARAMS_SVH
`define FPG_PARAMS_SVH
`define FPG_ADDR_ENABLE 8'h7F
`define FPG_ADDR_CONFIG 8'h80
`define FPG_ADDR_STATUS 8'h81
`define FPG_RESET_VALUE 8'h00
`define FPG_STATUS_LSB 4
`define FPG_ENABLE_USED_MASK 8'h0F
`define FPG_SEL_MSB 3
`define FPG_DIR_MSB 7
`define FPG_POL_MSB 6
`define FPG_PINS_RESET 4'h0
`define FPG_OE_RESET 4'hF
`endif

// [verilog/fpg_pkg.sv]
package fpg_pkg;
    typedef logic [7:0] fpg_byte_t;
    typedef logic [3:0] fpg_pins_t;
endpackage : fpg_pkg

// [verilog/fpg_sync.sv]
`timescale 1ns/1ps
// Two-flop synchroniser per pin
module fpg_sync #(
    parameter int WIDTH = 4
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_reg;
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            meta_reg <= '0;
            sync_out <= '0;
        end else begin
            meta_reg <= async_in;
            sync_out <= meta_reg;
        end
    end
endmodule : fpg_sync

// [tb/fpg_board.sv]
`timescale 1ns/1ps
// Board side: a pin the port releases shows the board's own level
module fpg_board (
    input wire fpg_pkg::fpg_pins_t pin_out,
    input wire fpg_pkg::fpg_pins_t pin_oe,
    input wire fpg_pkg::fpg_pins_t ext_level,
    output fpg_pkg::fpg_pins_t pin_in
);
    import fpg_pkg::*;
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_level);
endmodule : fpg_board

// [tb/fpg_port_tb_top.sv]
`timescale 1ns/1ps
module fpg_port_tb_top;
    import fpg_pkg::*;
    logic clk = 0;
    logic sys_rst = 1;
    logic we = 0;
    logic cyc = 0;
    logic stb = 0;
    logic ack;
    logic [3:0] sel = 0;
    logic [31:0] adr = 0;
    logic [31:0] dat = 0;
    logic [31:0] dat_o;
    logic [31:0] rd;
    fpg_pins_t fan = 4'hA;
    fpg_pins_t duty = 0;
    fpg_pins_t ext = 4'hC;
    fpg_pins_t pin_in;
    fpg_pins_t pout;
    fpg_pins_t poe;
    int fails = 0;
    int compares = 0;
    int ticks = 0;
    always #12.5 clk = ~clk;
    fpg_port uut (.clk(clk), .sys_rst(sys_rst), .wb_adr_i(adr), .wb_dat_i(dat), .wb_dat_o(dat_o),
        .wb_we_i(we), .wb_sel_i(sel), .wb_stb_i(stb), .wb_cyc_i(cyc), .wb_ack_o(ack),
        .fan_drive(fan), .min_duty_lsb(duty), .pin_in(pin_in), .pin_out(pout), .pin_oe(poe));
    fpg_board board (.pin_out(pout), .pin_oe(poe), .ext_level(ext), .pin_in(pin_in));
    task results;
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : results
    // A hung handshake would otherwise stall the run forever
    always @(posedge clk) begin
        ticks++;
        if (ticks == 3000) begin
            fails++;
            results();
        end
    end
    task cmp(input string n, input logic [31:0] e, input logic [31:0] s);
        compares++;
        if (s !== e) begin
            fails++;
            $display("FAIL %s expected %h seen %h", n, e, s);
        end
    endtask : cmp
    task wb(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        adr <= {24'h000000, a};
        dat <= {24'h000000, d};
        we <= w;
        sel <= 4'hF;
        cyc <= 1'b1;
        stb <= 1'b1;
        @(posedge clk);
        while (ack !== 1'b1) @(posedge clk);
        rd = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask : wb
    task rdchk(input string n, input logic [7:0] a, input logic [7:0] e);
        wb(1'b0, a, 8'h00);
        cmp(n, {24'h000000, e}, rd);
    endtask : rdchk
    task cmp_pin(input string n, input fpg_pins_t e, input fpg_pins_t s);
        compares++;
        if (s !== e) begin
            fails++;
            $display("FAIL %s expected %h seen %h", n, e, s);
        end
    endtask : cmp_pin
    // Input pins are not driven, so only driven bits of pin_out are compared
    task pins(input fpg_pins_t e_oe, input fpg_pins_t e_out);
        repeat (4) @(posedge clk);
        cmp_pin("pin_oe", e_oe, poe);
        cmp_pin("pin_out", e_out & e_oe, pout & poe);
    endtask : pins
    task t_reset;
        rdchk("enable", 8'h7F, 8'h00);
        rdchk("config", 8'h80, 8'h00);
        rdchk("status", 8'h81, 8'h00);
        pins(4'hF, fan);
        wb(1'b1, 8'h7F, 8'h0F);
        rdchk("enable", 8'h7F, 8'h0F);
        // All pins are active-low inputs now; the board holds pins 1 and 2 low
        rdchk("status", 8'h81, 8'h30);
    endtask : t_reset
    task t_gpio;
        wb(1'b1, 8'h80, 8'hE4);
        pins(4'h3, 4'h2);
        wb(1'b1, 8'h81, 8'hFF);
        pins(4'h3, 4'h1);
        rdchk("status", 8'h81, 8'h70);
        wb(1'b1, 8'h81, 8'h00);
        duty <= 4'h3;
        pins(4'h3, 4'h1);
        wb(1'b1, 8'h82, 8'hFF);
        rdchk("unmapped", 8'h82, 8'h00);
        rdchk("config", 8'h80, 8'hE4);
    endtask : t_gpio
    task t_release;
        wb(1'b1, 8'h7F, 8'h00);
        pins(4'hF, fan);
        rdchk("status", 8'h81, 8'h00);
        // A reset in mid-run must clear the config left by earlier scenarios
        sys_rst <= 1'b1;
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        rdchk("config", 8'h80, 8'h00);
        pins(4'hF, fan);
    endtask : t_release
    initial begin
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        t_reset();
        t_gpio();
        t_release();
        results();
    end
endmodule : fpg_port_tb_top
